// ---- rtl/iopin_top.sv ----
// io port and optical pin logic: registers, pin direction, optical conditioning
`timescale 1ns/10ps
`default_nettype none
module iopin_top
   import iopin_pkg::*;
#(
   parameter int SLOT = SLOT_CYCLES
) (
   // clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RESET_N,
   // register port
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic        REG_WR,
   input  wire logic [7:0]  REG_WDATA,
   output var  logic [7:0]  REG_RDATA,
   // segment select bits 24 to 39 and brownout state
   input  wire logic [15:0] SEGMENT_OR_IO_SELECT,
   input  wire logic        BROWNOUT,
   // optical configuration
   input  wire logic        TRANSMIT_INVERT_BIT,
   input  wire logic        RECEIVE_INVERT_BIT,
   input  wire logic        CARRIER_MODULATION_ENABLE,
   input  wire logic [1:0]  CARRIER_DUTY_SELECT,
   input  wire logic [1:0]  TRANSMIT_PIN_FUNCTION,
   input  wire logic        RECEIVE_PIN_RELEASE,
   input  wire logic        UART_PIN_MUX_ENABLE,
   input  wire logic        UART_PIN_MUX_SELECT,
   // internal sources and sink
   input  wire logic        OPTICAL_UART_TX,
   output var  logic        OPTICAL_UART_RX,
   input  wire logic        ACTIVE_ENERGY_PULSE,
   input  wire logic        REACTIVE_ENERGY_PULSE,
   // general pins 0 to 15, bit 0 is the pushbutton
   input  wire logic [15:0] GENERAL_IO_PIN_IN,
   output var  logic [15:0] GENERAL_IO_PIN_OUT,
   output var  logic [15:0] GENERAL_IO_PIN_OE_N,
   output var  logic [15:0] SEGMENT_OWNS_PIN,
   // optical pins
   input  wire logic        OPTICAL_RECEIVE_PIN,
   output var  logic        OPTICAL_TRANSMIT_PIN,
   // alternate uart pins
   output var  logic        ALTERNATE_UART_TX_PIN,
   output var  logic        ALTERNATE_UART_TX_OE_N,
   input  wire logic        ALTERNATE_UART_RX_PIN
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0]  data0_q;
   logic [7:0]  data1_q;
   logic [7:0]  dir0_q;
   logic [7:0]  dir1_q;
   logic [15:0] pin_s;
   logic [1:0]  opt_s;
   logic        brown_s;
   logic        carrier;

   iopin_sync #(.W(16)) u_pin_sync (
      .clk (SYS_CLK),
      .rst_n (RESET_N),
      .d (GENERAL_IO_PIN_IN),
      .q (pin_s)
   );

   iopin_sync #(.W(3)) u_opt_sync (
      .clk (SYS_CLK),
      .rst_n (RESET_N),
      .d ({BROWNOUT, OPTICAL_RECEIVE_PIN, ALTERNATE_UART_RX_PIN}),
      .q ({brown_s, opt_s})
   );

   // ----------------------------------------
   // register write and read
   // ----------------------------------------
   wire wr_data0 = REG_WR && (REG_ADDR == PORT0_DATA_ADDR);
   wire wr_data1 = REG_WR && (REG_ADDR == PORT1_DATA_ADDR);
   wire wr_dir0  = REG_WR && (REG_ADDR == PORT0_DIR_ADDR);
   wire wr_dir1  = REG_WR && (REG_ADDR == PORT1_DIR_ADDR);

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         data0_q <= DATA_RESET;
         data1_q <= DATA_RESET;
         dir0_q  <= DIR_RESET;
         dir1_q  <= DIR_RESET;
      end else begin
         if (wr_data0) data0_q <= REG_WDATA;
         if (wr_data1) data1_q <= REG_WDATA;
         if (wr_dir0)  dir0_q  <= {REG_WDATA[7:1], 1'b0};
         if (wr_dir1)  dir1_q  <= REG_WDATA;
      end
   end

   // ----------------------------------------
   // pin ownership and direction
   // ----------------------------------------
   wire [15:0] dir_all = {dir1_q, dir0_q};
   wire [15:0] data_all = {data1_q, data0_q};
   // pins 0-3 always digital, 4-15 from select bits
   wire [15:0] seg_own = {SEGMENT_OR_IO_SELECT[11:0], 4'h0};
   // optical transmit takes pin 2 when serving as gpio, receive takes pin 1
   wire tx_as_gpio = (TRANSMIT_PIN_FUNCTION == TXF_GPIO);
   wire rx_as_gpio = RECEIVE_PIN_RELEASE;
   wire [15:0] drive_en = dir_all & ~seg_own;

   // read returns sampled pin levels, optical pins stand in for 1 and 2
   wire [15:0] pin_view;
   assign pin_view[0]     = pin_s[0];
   assign pin_view[1]     = rx_as_gpio ? (opt_s[1] ^ RECEIVE_INVERT_BIT) : pin_s[1];
   assign pin_view[2]     = tx_as_gpio ? OPTICAL_TRANSMIT_PIN : pin_s[2];
   assign pin_view[15:3]  = pin_s[15:3];

   wire [7:0] rd_mux =
      (REG_ADDR == PORT0_DATA_ADDR) ? pin_view[7:0]  :
      (REG_ADDR == PORT1_DATA_ADDR) ? pin_view[15:8] :
      (REG_ADDR == PORT0_DIR_ADDR)  ? dir0_q         :
      (REG_ADDR == PORT1_DIR_ADDR)  ? dir1_q         : 8'h00;

   // ----------------------------------------
   // optical transmit path
   // ----------------------------------------
   // no carrier in brownout
   wire mod_run = CARRIER_MODULATION_ENABLE && !brown_s;
   // uart leaves optical pins when the mux is on
   wire mux_on = UART_PIN_MUX_ENABLE && UART_PIN_MUX_SELECT;

   iopin_carrier #(.SLOT(SLOT)) u_carrier (
      .clk (SYS_CLK),
      .rst_n (RESET_N),
      .run (mod_run),
      .duty (CARRIER_DUTY_SELECT),
      .carrier (carrier)
   );

   wire tx_src =
      (TRANSMIT_PIN_FUNCTION == TXF_GPIO)   ? data0_q[2] :
      (TRANSMIT_PIN_FUNCTION == TXF_ACTIVE) ? ACTIVE_ENERGY_PULSE :
      (TRANSMIT_PIN_FUNCTION == TXF_REACT)  ? REACTIVE_ENERGY_PULSE :
      (mux_on ? 1'b1 : OPTICAL_UART_TX);
   // carrier chops a low source, a high one passes
   wire tx_mod = mod_run ? (tx_src | carrier) : tx_src;
   wire tx_pin = tx_mod ^ TRANSMIT_INVERT_BIT;

   wire rx_src = mux_on ? opt_s[0] :
                 rx_as_gpio ? 1'b1 : (opt_s[1] ^ RECEIVE_INVERT_BIT);

   // ----------------------------------------
   // output flops
   // ----------------------------------------
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         REG_RDATA              <= 8'h00;
         GENERAL_IO_PIN_OUT     <= 16'h0000;
         GENERAL_IO_PIN_OE_N    <= 16'hffff;
         SEGMENT_OWNS_PIN       <= 16'h0000;
         OPTICAL_TRANSMIT_PIN   <= 1'b0;
         OPTICAL_UART_RX        <= 1'b1;
         ALTERNATE_UART_TX_PIN  <= 1'b1;
         ALTERNATE_UART_TX_OE_N <= 1'b1;
      end else begin
         REG_RDATA              <= rd_mux;
         GENERAL_IO_PIN_OUT     <= data_all;
         GENERAL_IO_PIN_OE_N    <= ~drive_en;
         SEGMENT_OWNS_PIN       <= seg_own;
         OPTICAL_TRANSMIT_PIN   <= tx_pin;
         OPTICAL_UART_RX        <= rx_src;
         ALTERNATE_UART_TX_PIN  <= OPTICAL_UART_TX;
         ALTERNATE_UART_TX_OE_N <= !mux_on;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   // set by the first direction write since reset
   logic dir_set_q;
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) dir_set_q <= 1'b0;
      else if (wr_dir0 || wr_dir1) dir_set_q <= 1'b1;
   end

   property p_reset_inputs;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      !dir_set_q |=> GENERAL_IO_PIN_OE_N == 16'hffff;
   endproperty
   a_reset_inputs: assert property (p_reset_inputs)
      else $error("pins not inputs after reset");

   property p_seg_no_drive;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      SEGMENT_OR_IO_SELECT[0] ##1 SEGMENT_OR_IO_SELECT[0] |-> GENERAL_IO_PIN_OE_N[4];
   endproperty
   a_seg_no_drive: assert property (p_seg_no_drive) else $error("segment pin driven");

   property p_dir_write;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      wr_dir1 && !SEGMENT_OR_IO_SELECT[4] ##1 !SEGMENT_OR_IO_SELECT[4]
         |-> ##1 GENERAL_IO_PIN_OE_N[8] == !$past(REG_WDATA[0], 2);
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("direction bit not applied");

   property p_pb_no_dir;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      wr_dir0 |=> dir0_q[PB_BIT] == 1'b0;
   endproperty
   a_pb_no_dir: assert property (p_pb_no_dir) else $error("pushbutton got direction");

   property p_low_pins_digital;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      ##1 SEGMENT_OWNS_PIN[3:0] == 4'h0;
   endproperty
   a_low_pins_digital: assert property (p_low_pins_digital)
      else $error("pins 0-3 segmented");

   property p_brownout_no_carrier;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      brown_s |=> carrier;
   endproperty
   a_brownout_no_carrier: assert property (p_brownout_no_carrier)
      else $error("carrier in brownout");

   property p_tx_invert;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      !mod_run && TRANSMIT_PIN_FUNCTION == TXF_ACTIVE
         |=> OPTICAL_TRANSMIT_PIN == ($past(ACTIVE_ENERGY_PULSE) ^ $past(TRANSMIT_INVERT_BIT));
   endproperty
   a_tx_invert: assert property (p_tx_invert) else $error("transmit invert wrong");

   property p_read_data;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      REG_ADDR == PORT1_DATA_ADDR |=> REG_RDATA == $past(pin_s[15:8]);
   endproperty
   a_read_data: assert property (p_read_data) else $error("port1 read wrong");

   property p_gpio_tx;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      !mod_run && TRANSMIT_PIN_FUNCTION == TXF_GPIO
         |=> OPTICAL_TRANSMIT_PIN == ($past(data0_q[2]) ^ $past(TRANSMIT_INVERT_BIT));
   endproperty
   a_gpio_tx: assert property (p_gpio_tx) else $error("pin 2 source wrong");

   property p_carrier_low;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      mod_run && !tx_src && !carrier |=> OPTICAL_TRANSMIT_PIN == $past(TRANSMIT_INVERT_BIT);
   endproperty
   a_carrier_low: assert property (p_carrier_low) else $error("carrier not low");

   property p_mark_clear;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      mod_run && tx_src |=> OPTICAL_TRANSMIT_PIN == !$past(TRANSMIT_INVERT_BIT);
   endproperty
   a_mark_clear: assert property (p_mark_clear) else $error("mark chopped");

   property p_rx_release;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      RECEIVE_PIN_RELEASE && !mux_on |=> OPTICAL_UART_RX;
   endproperty
   a_rx_release: assert property (p_rx_release) else $error("rx not released");

   property p_mux_rx;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      mux_on |=> OPTICAL_UART_RX == $past(opt_s[0]);
   endproperty
   a_mux_rx: assert property (p_mux_rx) else $error("mux rx wrong");

   property p_mux_tx;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      mux_on && TRANSMIT_PIN_FUNCTION == TXF_UART
         |=> OPTICAL_TRANSMIT_PIN == !$past(TRANSMIT_INVERT_BIT) && !ALTERNATE_UART_TX_OE_N;
   endproperty
   a_mux_tx: assert property (p_mux_tx) else $error("mux tx wrong");

   property p_pb_read;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      REG_ADDR == PORT0_DATA_ADDR |=> REG_RDATA[PB_BIT] == $past(pin_s[PB_BIT]);
   endproperty
   a_pb_read: assert property (p_pb_read) else $error("pushbutton read wrong");

   property p_data_out;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      wr_data1 |=> ##1 GENERAL_IO_PIN_OUT[15:8] == $past(REG_WDATA, 2);
   endproperty
   a_data_out: assert property (p_data_out) else $error("port1 data not driven");

   c_mod: cover property (@(posedge SYS_CLK) mod_run && !carrier);
   c_gpio_tx: cover property (@(posedge SYS_CLK) tx_as_gpio && OPTICAL_TRANSMIT_PIN);
   c_mux: cover property (@(posedge SYS_CLK) !ALTERNATE_UART_TX_OE_N);
endmodule
`default_nettype wire

// ---- rtl/iopin_pkg.sv ----
// package: register offsets, field layout, reset values and carrier timing for the io pin block
package iopin_pkg;
   // ----------------------------------------
   // register offsets (special function space)
   // ----------------------------------------
   localparam logic [7:0] PORT0_DATA_ADDR = 8'h80;
   localparam logic [7:0] PORT1_DATA_ADDR = 8'h90;
   localparam logic [7:0] PORT1_DIR_ADDR  = 8'h91;
   localparam logic [7:0] PORT0_DIR_ADDR  = 8'ha2;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0]  DIR_RESET     = 8'h00;
   localparam logic [7:0]  DATA_RESET    = 8'h00;
   localparam logic [15:0] SEG_SEL_RESET = 16'h0000;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int PB_BIT      = 0;
   localparam int FIRST_SHARED = 4;
   localparam int SEG_SEL_LO  = 24;
   // transmit pin function codes
   localparam logic [1:0] TXF_UART   = 2'h0;
   localparam logic [1:0] TXF_GPIO   = 2'h1;
   localparam logic [1:0] TXF_ACTIVE = 2'h2;
   localparam logic [1:0] TXF_REACT  = 2'h3;
   // ----------------------------------------
   // carrier timing
   // ----------------------------------------
   localparam int CLK_HZ       = 250_000_000;
   localparam int CARRIER_HZ   = 38_000;
   // sixteen phase slots per period, so 6.25% is one slot
   localparam int CARRIER_SLOTS = 16;
   localparam int SLOT_CYCLES  = CLK_HZ / (CARRIER_HZ * CARRIER_SLOTS);
endpackage

// ---- rtl/iopin_sync.sv ----
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/10ps
`default_nettype none
module iopin_sync #(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // levels
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/iopin_carrier.sv ----
// carrier generator: 16 slot phase counter, low for the selected share of each period
`timescale 1ns/10ps
`default_nettype none
module iopin_carrier
   import iopin_pkg::*;
#(
   parameter int SLOT = SLOT_CYCLES
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // control
   input  wire logic       run,
   input  wire logic [1:0] duty,
   // carrier level, low during the duty share
   output var  logic       carrier
);
   logic [15:0] div_q;
   logic [3:0]  phase_q;
   logic        slot_end;
   logic [3:0]  low_slots;

   assign slot_end = (div_q == 16'(SLOT - 1));
   // 0:50% 1:25% 2:12.5% 3:6.25%
   assign low_slots = 4'(8 >> duty);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q   <= '0;
         phase_q <= '0;
         carrier <= 1'b1;
      end else if (!run) begin
         div_q   <= '0;
         phase_q <= '0;
         carrier <= 1'b1;
      end else begin
         div_q <= slot_end ? 16'h0000 : div_q + 16'h0001;
         if (slot_end) begin
            phase_q <= phase_q + 4'h1;
         end
         carrier <= !(phase_q < low_slots);
      end
   end
endmodule
`default_nettype wire

// ---- test/iopin_far_side.sv ----
// far-side model: general pin wires, photodetector and alternate uart lines
`timescale 1ns/10ps
`default_nettype none
module iopin_far_side (
   // device outputs
   input  wire logic [15:0] pin_out,
   input  wire logic [15:0] pin_oe_n,
   input  wire logic        alt_tx,
   input  wire logic        alt_tx_oe_n,
   // levels from the outside world
   input  wire logic [15:0] ext_lvl,
   input  wire logic        light,
   input  wire logic        alt_line,
   // levels seen by the device and on the alternate tx wire
   output logic [15:0]      pin_in,
   output logic             optical_receive_pin,
   output logic             alt_rx,
   output logic             alt_wire
);
   // ----------------------------------------
   // wire resolution
   // ----------------------------------------
   // driven pin shows output
   assign pin_in   = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
   assign optical_receive_pin   = light;
   assign alt_rx   = alt_line;
   // released line shows the inverse so a stale level cannot pass
   assign alt_wire = alt_tx_oe_n ? ~alt_tx : alt_tx;
endmodule
`default_nettype wire

// ---- test/io_port_and_optical_pins_bench.sv ----
// bench: registers, pins and optical path against a reference model
`timescale 1ns/10ps
`default_nettype none
module io_port_and_optical_pins_bench;
   import iopin_pkg::*;
   localparam int SLOT_T = 2;
   logic        sys_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic        wr = 1'b0;
   logic [7:0]  wdata = 8'h00;
   logic [15:0] seg_sel = 16'h0000;
   logic [15:0] ext = 16'h0000;
   logic        brown = 1'b0, txinv = 1'b0, rxinv = 1'b0, cmod = 1'b0, rxrel = 1'b0;
   logic [1:0]  duty = 2'h0, txf = 2'h0;
   logic        mux_en = 1'b0, mux_sel = 1'b0, utx = 1'b1, apul = 1'b0, rpul = 1'b0;
   logic        light = 1'b1, alt_line = 1'b1, src;
   logic [7:0]  rdata, v;
   logic        urx, optical_receive_pin, optical_transmit_pin, alt_tx, alt_oe_n, alt_rx, alt_wire;
   logic [15:0] pin_in, pin_out, pin_oe_n, seg_own, e_oe, e_pin;
   int          miscompares = 0;
   int          total_checks = 0;
   int          d0, d1, t0, t1, lows, i;
   iopin_top #(.SLOT(SLOT_T)) iopin_top_inst (.SYS_CLK(sys_clk), .RESET_N(reset_n),
      .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RDATA(rdata),
      .SEGMENT_OR_IO_SELECT(seg_sel), .BROWNOUT(brown), .TRANSMIT_INVERT_BIT(txinv),
      .RECEIVE_INVERT_BIT(rxinv), .CARRIER_MODULATION_ENABLE(cmod),
      .CARRIER_DUTY_SELECT(duty), .TRANSMIT_PIN_FUNCTION(txf), .RECEIVE_PIN_RELEASE(rxrel),
      .UART_PIN_MUX_ENABLE(mux_en), .UART_PIN_MUX_SELECT(mux_sel), .OPTICAL_UART_TX(utx),
      .OPTICAL_UART_RX(urx), .ACTIVE_ENERGY_PULSE(apul), .REACTIVE_ENERGY_PULSE(rpul),
      .GENERAL_IO_PIN_IN(pin_in), .GENERAL_IO_PIN_OUT(pin_out),
      .GENERAL_IO_PIN_OE_N(pin_oe_n), .SEGMENT_OWNS_PIN(seg_own),
      .OPTICAL_RECEIVE_PIN(optical_receive_pin), .OPTICAL_TRANSMIT_PIN(optical_transmit_pin),
      .ALTERNATE_UART_TX_PIN(alt_tx), .ALTERNATE_UART_TX_OE_N(alt_oe_n),
      .ALTERNATE_UART_RX_PIN(alt_rx));
   iopin_far_side iopin_far_side_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .alt_tx(alt_tx), .alt_tx_oe_n(alt_oe_n), .ext_lvl(ext), .light(light),
      .alt_line(alt_line), .pin_in(pin_in), .optical_receive_pin(optical_receive_pin), .alt_rx(alt_rx),
      .alt_wire(alt_wire));
   always #2 sys_clk = ~sys_clk;
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      total_checks++;
      if (seen !== want) begin
         miscompares++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
      tick(1);
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      addr = a;
      tick(1);
      d = rdata;
   endtask
   task automatic count_lows();
      lows = 0;
      repeat (128) begin
         tick(1);
         if (optical_transmit_pin !== 1'b1) lows++;
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      miscompares++;
      give_verdict();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(68092));
      tick(2);
      check(pin_oe_n, 16'hffff);
      tick(1);
      reset_n = 1'b1;
      rd_reg(PORT1_DIR_ADDR, v);
      check(16'(v), 16'h0000);
      $display("test reset done");
      for (i = 0; i < 8; i++) begin
         d0 = $urandom & 8'hff;
         d1 = $urandom & 8'hff;
         t0 = $urandom & 8'hff;
         t1 = $urandom & 8'hff;
         seg_sel = 16'($urandom);
         ext = 16'($urandom);
         wr_reg(PORT0_DIR_ADDR, 8'(d0));
         wr_reg(PORT1_DIR_ADDR, 8'(d1));
         wr_reg(PORT0_DATA_ADDR, 8'(t0));
         wr_reg(PORT1_DATA_ADDR, 8'(t1));
         wr_reg(8'h81, 8'($urandom));
         e_oe = 16'hffff;
         for (int k = 1; k < 16; k++)
            if ((((d1 << 8) | d0) >> k) & 1 && !(k >= 4 && seg_sel[k-4])) e_oe[k] = 1'b0;
         e_pin = (16'((t1 << 8) | t0) & ~e_oe) | (ext & e_oe);
         tick(4);
         check(pin_oe_n, e_oe);
         check(seg_own, {seg_sel[11:0], 4'h0});
         check(pin_out, 16'((t1 << 8) | t0));
         rd_reg(PORT0_DIR_ADDR, v);
         check(16'(v), 16'(d0 & 8'hfe));
         rd_reg(PORT1_DIR_ADDR, v);
         check(16'(v), 16'(d1));
         rd_reg(PORT0_DATA_ADDR, v);
         check(16'(v), 16'(e_pin[7:0]));
         rd_reg(PORT1_DATA_ADDR, v);
         check(16'(v), 16'(e_pin[15:8]));
         rd_reg(8'h81, v);
         check(16'(v), 16'h0000);
      end
      $display("test registers done");
      wr_reg(PORT0_DIR_ADDR, 8'h04);
      for (i = 0; i < 8; i++) begin
         t0 = $urandom & 8'hff;
         wr_reg(PORT0_DATA_ADDR, 8'(t0));
         {utx, apul, rpul} = 3'($urandom);
         txf = i[1:0];
         txinv = i[2];
         src = (txf == TXF_UART) ? utx : (txf == TXF_GPIO) ? t0[2] :
               (txf == TXF_ACTIVE) ? apul : rpul;
         tick(6);
         check(16'(optical_transmit_pin), 16'(src ^ txinv));
      end
      {txf, txinv} = 3'h0;
      for (i = 0; i < 4; i++) begin
         {light, rxinv} = i[1:0];
         tick(6);
         check(16'(urx), 16'(light ^ rxinv));
      end
      {rxrel, rxinv} = 2'b10;
      light = 1'($urandom);
      tick(6);
      check(16'(urx), 16'h0001);
      rd_reg(PORT0_DATA_ADDR, v);
      check(16'(v[1]), 16'(light));
      rxrel = 1'b0;
      for (i = 0; i < 4; i++) begin
         {mux_sel, mux_en} = i[1:0];
         {alt_line, utx} = 2'($urandom);
         tick(6);
         check(16'(alt_oe_n), 16'(i != 3));
         if (i == 3) begin
            check(16'(alt_wire), 16'(utx));
            check(16'(urx), 16'(alt_line));
            check(16'(optical_transmit_pin), 16'h0001);
         end
      end
      // a low source is chopped by the carrier, a high one never is
      {mux_sel, mux_en, utx, cmod} = 4'h1;
      $display("test optical pins done");
      for (i = 0; i < 4; i++) begin
         duty = i[1:0];
         tick(40);
         count_lows();
         check(16'(lows), 16'(4 * SLOT_T * (8 >> i)));
      end
      // brownout leaves the low source unchopped, low all the time
      brown = 1'b1;
      tick(40);
      count_lows();
      check(16'(lows), 16'h0080);
      {brown, utx} = 2'b01;
      tick(40);
      count_lows();
      check(16'(lows), 16'h0000);
      $display("test carrier done");
      reset_n = 1'b0;
      tick(2);
      check(pin_oe_n, 16'hffff);
      reset_n = 1'b1;
      rd_reg(PORT0_DIR_ADDR, v);
      check(16'(v), 16'h0000);
      $display("test second reset done");
      give_verdict();
   end
endmodule
`default_nettype wire
